// ### fwbp_ctrl.sv
// host controller driving the buffered program sequence of a x16 nor flash
// Overview of operation
// - one operation stays within one aligned 512-byte line
// - partial loads start anywhere but never cross the line boundary
// - whole aligned lines are fastest; partial pages are still allowed
// - host sends two unlock writes then load command at sector address
// - fourth write holds word count minus one at the same sector
// - data addresses ascend sequentially inside the chosen line
// - host sends confirm at sector address; device programs alone
// - hardware reset stops the sequence; area must be redone
// - host issues abort reset on abort bit, reset on timeout bit
`default_nettype none
module fwbp_ctrl
  import fwbp_pkg::*;
#(
  parameter int LINE_W = 8,
  parameter int SECT_LO = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fwbp_cmd_s cmd,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [FWBP_DATA_W-1:0] wr_data,
  input wire logic hw_reset_req,
  output logic busy,
  output logic done,
  output fwbp_stat_s stat,
  output logic dev_ready,
  output logic [FWBP_ADDR_W-1:0] flash_addr,
  output logic [FWBP_DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [FWBP_DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_rst_n,
  input wire logic flash_ready_busy
);
  // ****************************************************************
  // state
  // ****************************************************************
  fwbp_step_e step_r, step_nxt;
  fwbp_phase_e phase_r, phase_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [FWBP_ADDR_W-1:0] start_r;
  logic [FWBP_ADDR_W-1:0] addr_r;
  logic [FWBP_WC_W-1:0] wc_r;
  logic [FWBP_WC_W-1:0] left_r;
  logic [FWBP_DATA_W-1:0] last_r;
  logic [FWBP_ADDR_W-1:0] baddr_r;
  logic [FWBP_DATA_W-1:0] bdata_r;
  logic we_n_r, oe_n_r, ce_n_r, dq_oe_r, rst_n_r, rdy_r;
  fwbp_stat_s stat_r, stat_nxt;
  logic [8:0] wr_cnt_r;
  logic fifo_ov;
  logic [FWBP_DATA_W-1:0] fifo_od;
  // ****************************************************************
  // data fifo
  // ****************************************************************
  wire launch;
  wire fifo_pop = launch && step_r == S_DATA;
  fwbp_fifo #(.W(FWBP_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_ov),
    .out_ready(fifo_pop),
    .out_data(fifo_od)
  );
  // ****************************************************************
  // decode
  // ****************************************************************
  // partial lines are allowed; the line check only bounds the end
  wire [LINE_W:0] end_off = {1'b0, cmd.addr[LINE_W-1:0]}
                          + (LINE_W+1)'(cmd.wc);
  wire range_ok = !end_off[LINE_W];
  wire accept = cmd_valid && cmd_ready;
  wire is_read = step_r == S_POLL || step_r == S_REPOLL;
  wire bus_step = step_r != S_IDLE && step_r != S_DONE
               && step_r != S_HWRST;
  wire cnt_zero = cnt_r == 8'h00;
  wire op_end = cnt_zero && (phase_r == P_WHIGH || phase_r == P_RLOW);
  assign launch = phase_r == P_IDLE && bus_step && !hw_reset_req
                  && (step_r != S_DATA || fifo_ov);
  wire sel_u1 = step_r == S_UNLK1 || step_r == S_ABT1;
  wire sel_u2 = step_r == S_UNLK2 || step_r == S_ABT2;
  wire sel_rst = step_r == S_ABT3 || step_r == S_SWRST;
  wire sel_line = step_r == S_DATA || is_read;
  wire [FWBP_ADDR_W-1:0] cur_addr =
    (sel_u1 || sel_rst) ? ADDR_UNLK1 :
    sel_u2 ? ADDR_UNLK2 :
    sel_line ? addr_r : start_r;
  wire [FWBP_DATA_W-1:0] cur_data =
    sel_u1 ? DATA_UNLK1 :
    sel_u2 ? DATA_UNLK2 :
    step_r == S_LOAD ? CMD_LOAD :
    step_r == S_COUNT ? {{(FWBP_DATA_W-FWBP_WC_W){1'b0}}, wc_r} :
    step_r == S_DATA ? fifo_od :
    step_r == S_CONFIRM ? CMD_CONFIRM : CMD_RESET;
  wire dq7_match = flash_dq_in[POLL_DATA_BIT] == last_r[POLL_DATA_BIT];
  wire dq_abort = flash_dq_in[POLL_ABORT_BIT];
  wire dq_tmo = flash_dq_in[POLL_TIMEOUT_BIT];
  wire data_more = left_r != '0;
  assign cmd_ready = step_r == S_IDLE && !hw_reset_req;
  assign busy = step_r != S_IDLE;
  assign done = step_r == S_DONE;
  assign stat = stat_r;
  assign dev_ready = rdy_r;
  assign flash_addr = baddr_r;
  assign flash_dq_out = bdata_r;
  assign flash_dq_oe = dq_oe_r;
  assign flash_ce_n = ce_n_r;
  assign flash_we_n = we_n_r;
  assign flash_oe_n = oe_n_r;
  assign flash_rst_n = rst_n_r;
  // ****************************************************************
  // bus phase sequencer
  // ****************************************************************
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_zero ? cnt_r : cnt_r - 8'h01;
    case (phase_r)
      P_IDLE: begin
        if (launch) begin
          phase_nxt = P_SET;
          cnt_nxt = AS_CYC - 8'h01;
        end
      end
      P_SET: begin
        if (cnt_zero) begin
          phase_nxt = is_read ? P_RLOW : P_WLOW;
          cnt_nxt = is_read ? ACC_CYC - 8'h01 : WP_CYC - 8'h01;
        end
      end
      P_WLOW: begin
        if (cnt_zero) begin
          phase_nxt = P_WHIGH;
          cnt_nxt = WPH_CYC - 8'h01;
        end
      end
      P_WHIGH, P_RLOW: begin
        if (cnt_zero) phase_nxt = P_IDLE;
      end
      default: phase_nxt = P_IDLE;
    endcase
    if (hw_reset_req) begin
      phase_nxt = P_IDLE;
      cnt_nxt = RP_CYC - 8'h01;
    end
  end
  // ****************************************************************
  // command step sequencer
  // ****************************************************************
  always_comb begin
    step_nxt = step_r;
    stat_nxt = stat_r;
    case (step_r)
      S_IDLE: begin
        if (accept) begin
          stat_nxt = '0;
          step_nxt = range_ok ? S_UNLK1 : S_DONE;
          stat_nxt.refused = !range_ok;
        end
      end
      S_UNLK1: if (op_end) step_nxt = S_UNLK2;
      S_UNLK2: if (op_end) step_nxt = S_LOAD;
      S_LOAD: if (op_end) step_nxt = S_COUNT;
      S_COUNT: if (op_end) step_nxt = S_DATA;
      S_DATA: begin
        if (op_end && !data_more) step_nxt = S_CONFIRM;
      end
      S_CONFIRM: if (op_end) step_nxt = S_POLL;
      S_POLL: begin
        if (op_end) begin
          if (dq7_match) begin
            step_nxt = S_DONE;
            stat_nxt.ok = 1'b1;
          end else if (dq_abort) begin
            step_nxt = S_ABT1;
            stat_nxt.buffer_abort = 1'b1;
          end else if (dq_tmo) begin
            step_nxt = S_REPOLL;
          end
        end
      end
      S_REPOLL: begin
        if (op_end) begin
          step_nxt = dq7_match ? S_DONE : S_SWRST;
          stat_nxt.ok = dq7_match;
          stat_nxt.timeout = !dq7_match;
        end
      end
      S_ABT1: if (op_end) step_nxt = S_ABT2;
      S_ABT2: if (op_end) step_nxt = S_ABT3;
      S_ABT3, S_SWRST: if (op_end) step_nxt = S_DONE;
      S_HWRST: if (cnt_zero) step_nxt = S_DONE;
      S_DONE: step_nxt = S_IDLE;
      default: step_nxt = S_IDLE;
    endcase
    if (hw_reset_req) begin
      step_nxt = S_HWRST;
      stat_nxt = '0;
      stat_nxt.interrupted = 1'b1;
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_r <= S_IDLE;
      phase_r <= P_IDLE;
      cnt_r <= 8'h00;
      stat_r <= '0;
    end else begin
      step_r <= step_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      stat_r <= stat_nxt;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      start_r <= '0;
      wc_r <= '0;
    end else if (accept) begin
      start_r <= cmd.addr;
      wc_r <= cmd.wc;
    end
  end
  // address walks upward and stays on the last word for polling
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_r <= '0;
      left_r <= '0;
    end else if (accept) begin
      addr_r <= cmd.addr;
      left_r <= cmd.wc;
    end else if (op_end && step_r == S_DATA && data_more) begin
      addr_r <= addr_r + 1'b1;
      left_r <= left_r - 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_r <= '0;
      baddr_r <= '0;
      bdata_r <= '0;
    end else if (launch) begin
      if (fifo_pop) last_r <= fifo_od;
      baddr_r <= cur_addr;
      bdata_r <= cur_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      ce_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
      rst_n_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      we_n_r <= phase_nxt != P_WLOW;
      oe_n_r <= phase_nxt != P_RLOW;
      ce_n_r <= phase_nxt == P_IDLE;
      dq_oe_r <= phase_nxt == P_SET && !is_read
                 || phase_nxt == P_WLOW || phase_nxt == P_WHIGH;
      rst_n_r <= step_nxt != S_HWRST;
      rdy_r <= flash_ready_busy;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || accept) wr_cnt_r <= '0;
    else if (op_end && step_r == S_DATA) wr_cnt_r <= wr_cnt_r + 9'h001;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  we_pulse_len_a: assert property ($fell(flash_we_n) |->
    (!flash_we_n)[*4] ##1 flash_we_n)
    else $error("write strobe width wrong");
  unlock_order_a: assert property (step_r == S_LOAD && $changed(step_r)
    |-> $past(step_r) == S_UNLK2)
    else $error("load command not preceded by unlock");
  load_code_a: assert property (step_r == S_LOAD && !flash_we_n |->
    flash_dq_out == CMD_LOAD
    && flash_addr[FWBP_ADDR_W-1:SECT_LO]
       == start_r[FWBP_ADDR_W-1:SECT_LO])
    else $error("load command wrong");
  count_word_a: assert property (step_r == S_COUNT && !flash_we_n |->
    flash_dq_out[FWBP_WC_W-1:0] == wc_r
    && flash_addr == start_r)
    else $error("word count write wrong");
  line_stay_a: assert property (step_r == S_DATA && !flash_we_n |->
    flash_addr[FWBP_ADDR_W-1:LINE_W]
    == start_r[FWBP_ADDR_W-1:LINE_W])
    else $error("data write left the line");
  word_total_a: assert property (step_r == S_CONFIRM && $changed(step_r)
    |-> wr_cnt_r == {1'b0, wc_r} + 9'h001)
    else $error("confirm after wrong word total");
  confirm_code_a: assert property (step_r == S_CONFIRM && !flash_we_n
    |-> flash_dq_out == CMD_CONFIRM && flash_addr == start_r)
    else $error("confirm command wrong");
  range_refuse_a: assert property (accept && !range_ok |=>
    step_r == S_DONE && stat_r.refused ##1 step_r == S_IDLE)
    else $error("line crossing request not refused");
  abort_reset_a: assert property (step_r == S_POLL && op_end
    && !dq7_match && dq_abort && !hw_reset_req |=>
    step_r == S_ABT1 && stat_r.buffer_abort)
    else $error("abort bit not followed by abort reset");
  hw_reset_a: assert property (hw_reset_req |=>
    !flash_rst_n && flash_ce_n [*2])
    else $error("hardware reset not driven");
  done_ok_c: cover property (step_r == S_POLL ##[1:1000] stat_r.ok);
  abort_c: cover property (step_r == S_ABT3 ##[1:100] done);
  timeout_c: cover property (step_r == S_SWRST);
  refuse_c: cover property (accept && !range_ok);
endmodule
`default_nettype wire

// ### fwbp_pkg.sv
// constants, types and timing for the flash buffered-program host controller
`default_nettype none
package fwbp_pkg;
  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int FWBP_ADDR_W = 26;
  localparam int FWBP_DATA_W = 16;
  localparam int FWBP_WC_W = 8;
  // ****************************************************************
  // command codes and unlock addresses
  // ****************************************************************
  localparam logic [FWBP_ADDR_W-1:0] ADDR_UNLK1 = 26'h0000555;
  localparam logic [FWBP_ADDR_W-1:0] ADDR_UNLK2 = 26'h00002aa;
  localparam logic [FWBP_DATA_W-1:0] DATA_UNLK1 = 16'h00aa;
  localparam logic [FWBP_DATA_W-1:0] DATA_UNLK2 = 16'h0055;
  localparam logic [FWBP_DATA_W-1:0] CMD_LOAD = 16'h0025;
  localparam logic [FWBP_DATA_W-1:0] CMD_CONFIRM = 16'h0029;
  localparam logic [FWBP_DATA_W-1:0] CMD_RESET = 16'h00f0;
  // ****************************************************************
  // data polling bit positions
  // ****************************************************************
  localparam int POLL_DATA_BIT = 7;
  localparam int POLL_TIMEOUT_BIT = 5;
  localparam int POLL_ABORT_BIT = 1;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 10;
  localparam int T_AS_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 100;
  localparam int T_RP_NS = 200;
  localparam logic [7:0] AS_CYC = 8'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [FWBP_ADDR_W-1:0] addr;
    logic [FWBP_WC_W-1:0] wc;
  } fwbp_cmd_s;
  typedef struct packed {
    logic ok;
    logic buffer_abort;
    logic timeout;
    logic refused;
    logic interrupted;
  } fwbp_stat_s;
  typedef enum logic [3:0] {
    S_IDLE, S_UNLK1, S_UNLK2, S_LOAD, S_COUNT, S_DATA, S_CONFIRM,
    S_POLL, S_REPOLL, S_ABT1, S_ABT2, S_ABT3, S_SWRST, S_HWRST, S_DONE
  } fwbp_step_e;
  typedef enum logic [2:0] {
    P_IDLE, P_SET, P_WLOW, P_WHIGH, P_RLOW
  } fwbp_phase_e;
endpackage
`default_nettype wire

// ### fwbp_fifo.sv
// data fifo with registered read port
`default_nettype none
module fwbp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic ov_r;
  logic [W-1:0] od_r;
  wire wr = in_valid && in_ready;
  wire rd = (cnt_r != '0) && (!ov_r || out_ready);
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = ov_r;
  assign out_data = od_r;
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) rp_r <= rp_r + 1'b1;
      if (wr && !rd) cnt_r <= cnt_r + 1'b1;
      else if (rd && !wr) cnt_r <= cnt_r - 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else if (rd) begin
      ov_r <= 1'b1;
      od_r <= mem[rp_r];
    end else if (out_ready) begin
      ov_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### fwbp_flash_model.sv
// behavioural x16 nor flash answering the buffered program sequence
`default_nettype none
module fwbp_flash_model
  import fwbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [FWBP_ADDR_W-1:0] flash_addr,
  input wire logic [FWBP_DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [FWBP_DATA_W-1:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_rst_n,
  output logic flash_ready_busy,
  input wire logic [1:0] mode,
  input wire logic [11:0] busy_cyc
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // state: 0 idle 1 count 2 data 3 confirm 4 busy 5 aborted 6 failed
  // ****************************************************************
  logic [15:0] mem [int];
  logic [15:0] wbuf [256];
  int st = 0;
  int ustep = 0;
  int left = 0;
  int nwr = 0;
  int bl = 0;
  logic [9:0] sect;
  logic [17:0] line;
  logic [25:0] nxt;
  logic [15:0] rd_val, m;
  logic [15:0] hold = 16'h0000;
  logic we_q = 1'b1;
  logic first = 1'b0;
  logic pf = 1'b0;
  logic ba = 1'b0;
  function automatic logic [15:0] mem_rd(input logic [25:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  task automatic abort_op();
    pf = 1'b1;
    ba = 1'b1;
    st = 5;
  endtask
  task automatic take_wr(input logic [25:0] a, input logic [15:0] d);
    nwr++;
    case (st)
      1: if (a[25:16] != sect || d > 16'h00ff || mode == 2'h1)
        abort_op();
      else begin
        left = int'(d) + 1;
        first = 1'b1;
        st = 2;
      end
      2: if (first ? (a[25:16] != sect) : (a[25:8] != line || a != nxt))
        abort_op();
      else begin
        line = a[25:8];
        wbuf[a[7:0]] = d;
        nxt = a + 26'h1;
        first = 1'b0;
        left--;
        if (left == 0) st = 3;
      end
      3: if (d == CMD_CONFIRM && a[25:16] == sect) begin
        for (int i = 0; i < 256; i++)
          mem[{line, 8'(i)}] = mem_rd({line, 8'(i)}) & wbuf[i];
        bl = int'(busy_cyc);
        st = 4;
      end else abort_op();
      4: ;
      default: begin
        if (d == CMD_RESET && (st == 6 || (st == 5 && ustep == 2))) begin
          st = 0;
          ustep = 0;
        end else if (st == 0 && ustep == 2 && d == CMD_LOAD) begin
          sect = a[25:16];
          for (int i = 0; i < 256; i++) wbuf[i] = 16'hffff;
          ustep = 0;
          st = 1;
        end else if (a == ADDR_UNLK1 && d == DATA_UNLK1) ustep = 1;
        else if (ustep == 1 && a == ADDR_UNLK2 && d == DATA_UNLK2) ustep = 2;
        else ustep = 0;
      end
    endcase
  endtask
  always @(posedge clk_sys) begin
    if (!flash_rst_n) begin
      st = 0;
      ustep = 0;
    end else begin
      if (!we_q && flash_we_n && !flash_ce_n && flash_dq_oe) begin
        take_wr(flash_addr, flash_dq_out);
      end
      if (st == 4) begin
        if (bl > 0) bl--;
        else if (mode == 2'h2) st = 6;
        else begin
          st = 0;
          pf = 1'b0;
          ba = 1'b0;
        end
      end
    end
    we_q = flash_we_n;
  end
  // polling word in states 4 to 6: inverted bit 7, bit 5 failure, bit 1 abort
  always_comb begin
    m = mem_rd(flash_addr);
    rd_val = (st < 4) ? m
           : {8'h00, ~m[7], 1'b0, st == 6, 3'h0, st == 5, 1'b0};
  end
  // a released bus shows the inverse of the last word read
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && !flash_dq_oe)
                       ? rd_val : ~hold;
  always @(posedge clk_sys) begin
    if (!flash_ce_n && !flash_oe_n) hold <= rd_val;
  end
  assign flash_ready_busy = (st != 4);
endmodule
`default_nettype wire

// ### fwbp_ctrl_tb.sv
// self-checking bench for the buffered program host controller
`default_nettype none
module fwbp_ctrl_tb
  import fwbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic hw_reset_req = 1'b0;
  fwbp_cmd_s cmd = '0;
  logic [FWBP_DATA_W-1:0] wr_data = '0;
  logic [1:0] mode = 2'h0;
  logic [11:0] busy_cyc = 12'h020;
  logic cmd_ready, wr_ready, busy, done, dev_ready, flash_ready_busy;
  fwbp_stat_s stat;
  logic [FWBP_ADDR_W-1:0] flash_addr;
  logic [FWBP_DATA_W-1:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_rst_n;
  int n_fail = 0;
  int n_checks = 0;
  fwbp_ctrl u_dut (.clk_sys, .sys_rst, .cmd_valid, .cmd_ready, .cmd,
    .wr_valid, .wr_ready, .wr_data, .hw_reset_req, .busy, .done, .stat,
    .dev_ready, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n, .flash_ready_busy);
  fwbp_flash_model u_flash (.clk_sys, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_rst_n, .flash_ready_busy, .mode, .busy_cyc);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wait_done(input int lim);
    // done stands one cycle only, so look before the next edge too
    for (int k = 0; k < lim; k++) begin
      #1;
      if (done === 1'b1) return;
      @(posedge clk_sys);
    end
    chk(1'b0, "no done");
    summarize();
  endtask
  task automatic push(input int n, input logic [15:0] base);
    int i;
    i = 0;
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_data <= base;
    for (int k = 0; k < 20000; k++) begin
      @(posedge clk_sys);
      if (wr_ready === 1'b1) begin
        i++;
        if (i == n) begin
          wr_valid <= 1'b0;
          return;
        end
        wr_data <= base + 16'(i);
      end
    end
    chk(1'b0, "push stuck");
    summarize();
  endtask
  task automatic cmd_go(input logic [25:0] a, input logic [7:0] wc);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{addr: a, wc: wc};
    for (int k = 0; k < 1000; k++) begin
      @(posedge clk_sys);
      if (cmd_ready === 1'b1) begin
        cmd_valid <= 1'b0;
        return;
      end
    end
    chk(1'b0, "command not taken");
    summarize();
  endtask
  task automatic prog(input logic [25:0] a, input logic [7:0] wc,
    input logic [15:0] base, input bit pre);
    int w0;
    w0 = u_flash.nwr;
    fork
      if (!pre) push(int'(wc) + 1, base);
      cmd_go(a, wc);
    join
    wait_done(20000);
    chk(stat.ok === 1'b1, "status not ok");
    chk(u_flash.nwr - w0 == int'(wc) + 6, "write count");
    for (int i = 0; i <= int'(wc); i++)
      chk(u_flash.mem_rd(a + 26'(i)) === base + 16'(i), "data");
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_line();
    prog(26'h0000100, 8'hff, 16'h8000, 1'b0);
    prog(26'h00001ff, 8'h00, 16'h0000, 1'b0);
    chk(u_flash.mem_rd(26'h00001fe) === 16'h80fe, "neighbour");
  endtask
  task automatic t_refuse();
    int w0;
    w0 = u_flash.nwr;
    cmd_go(26'h0000380, 8'h80);
    wait_done(3);
    chk(stat.refused === 1'b1, "not refused");
    chk(u_flash.nwr == w0 && flash_ce_n === 1'b1, "bus used");
  endtask
  task automatic t_abort();
    mode = 2'h1;
    fork
      push(4, 16'h0080);
      cmd_go(26'h0010000, 8'h03);
    join
    wait_done(5000);
    chk(stat.buffer_abort === 1'b1, "abort flag");
    chk(u_flash.pf === 1'b1 && u_flash.ba === 1'b1, "device flags");
    chk(u_flash.st == 0, "abort reset");
    mode = 2'h0;
  endtask
  task automatic t_timeout();
    mode = 2'h2;
    fork
      push(2, 16'h1234);
      cmd_go(26'h0010100, 8'h01);
    join
    wait_done(5000);
    chk(stat.timeout === 1'b1, "timeout flag");
    chk(u_flash.st == 0, "software reset");
    mode = 2'h0;
  endtask
  task automatic t_fifo();
    busy_cyc = 12'd600;
    push(33, 16'h4000);
    #1;
    chk(wr_ready === 1'b0, "fifo full");
    prog(26'h0020010, 8'h20, 16'h4000, 1'b1);
    chk(wr_ready === 1'b1, "fifo empty");
    chk(u_flash.pf === 1'b0, "fail flag kept");
  endtask
  task automatic t_hwrst();
    int n;
    n = 0;
    busy_cyc = 12'd300;
    fork
      push(1, 16'h5555);
      cmd_go(26'h0030000, 8'h00);
    join
    for (int k = 0; k < 500; k++) begin
      @(posedge clk_sys);
      #1;
      if (flash_ready_busy === 1'b0) break;
      if (k == 499) begin
        chk(1'b0, "device never busy");
        summarize();
      end
    end
    @(posedge clk_sys);
    #1;
    chk(dev_ready === 1'b0, "ready mirror");
    @(posedge clk_sys);
    hw_reset_req <= 1'b1;
    @(posedge clk_sys);
    hw_reset_req <= 1'b0;
    for (int k = 0; k < 100; k++) begin
      #1;
      if (flash_rst_n === 1'b0) n++;
      if (done === 1'b1) break;
      if (k == 99) begin
        chk(1'b0, "reset never ended");
        summarize();
      end
      @(posedge clk_sys);
    end
    chk(n == int'(RP_CYC), "reset pulse");
    chk(stat.interrupted === 1'b1, "not interrupted");
    busy_cyc = 12'd20;
    prog(26'h0030000, 8'h00, 16'h5555, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    chk(flash_rst_n === 1'b0 && flash_ce_n === 1'b1 && busy === 1'b0,
      "reset");
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_line();
    t_refuse();
    t_abort();
    t_timeout();
    t_fifo();
    t_hwrst();
    summarize();
  end
endmodule
`default_nettype wire
